//--- otp_host.sv
/*
 * otp_host: programmer that drives an otp word memory through its pins.
 * runs program, verify with retry, final read-back and id read.
 * assumes the source word is valid in the same cycle as src_req_out, and that
 * an external regulator follows supply_sel_out and hv_id_en_out.
 */
// What this block does
// R1 - strobe held low 95 to 105 us
// R2 - first address, raise supplies before programming
// R3 - first pass: one pulse per word, no verify
// R4 - failed verify: up to 10 single retry pulses
// R5 - still failing after 10: stop, flag failure
// R6 - verified word: advance until all checked
// R7 - drop supplies to 5V, read and compare all
// R8 - id select low maker, high part code
// R9 - device floats outputs when selects go high
// R10 - id mode: address low, id line high voltage
// R11 - two id words, chosen by select line
// R12 - program and verify pin combinations
`timescale 1ns/1ns
`default_nettype none
module otp_host #(
    parameter int PULSE_CYCLES = otp_pkg::PULSE_CYC,   // shorten for simulation
    parameter int LAST_ADDR    = 16'hffff
) (
    input  wire logic                          ref_clk_in,
    input  wire logic                          rst_b_in,
    input  wire logic                          start_prog_in,   // pulse
    input  wire logic                          start_id_in,     // pulse
    input  wire logic [otp_pkg::DATA_W-1:0]    src_data_in,     // source word
    input  wire logic [otp_pkg::DATA_W-1:0]    word_outputs_in, // from device
    output logic      [otp_pkg::ADDR_W-1:0]    word_address_lines_out,
    output logic      [otp_pkg::DATA_W-1:0]    word_drive_out,
    output logic                               word_drive_oe_out,
    output logic                               chip_sel_n_out,
    output logic                               out_drive_n_out,
    output logic                               program_strobe_n_out,
    output logic      [1:0]                    supply_sel_out,
    output logic                               hv_id_en_out,
    output logic                               src_req_out,
    output logic                               busy_out,
    output logic                               done_out,
    output logic                               pass_out,
    output logic                               fail_out,
    output logic      [otp_pkg::DATA_W-1:0]    maker_id_out,
    output logic      [otp_pkg::DATA_W-1:0]    part_id_out
);
    // =========================================================
    // elaboration checks
    initial begin
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 32'h10000 || LAST_ADDR < 0 ||
            LAST_ADDR > 16'hffff) begin
            $error("otp_host: bad parameter");
        end
    end

    // =========================================================
    // state
    typedef enum logic [3:0] {
        S_IDLE, S_SUPPLY, S_FETCH, S_SETUP, S_PULSE, S_HOLD,
        S_VREAD, S_VCMP, S_NEXT, S_DONE, S_ID_SET, S_ID_READ
    } otp_state_t;
    typedef enum logic [1:0] { P_FIRST, P_VERIFY, P_FINAL } otp_phase_t;

    typedef struct packed {
        otp_state_t                  st;
        otp_phase_t                  ph;
        logic [otp_pkg::ADDR_W-1:0]  addr;
        logic [otp_pkg::DATA_W-1:0]  wdat;
        logic                        woe;
        logic                        ce_n;
        logic                        oe_n;
        logic                        stb_n;
        logic [1:0]                  sup;
        logic                        hv;
        logic                        req;
        logic                        busy;
        logic                        done;
        logic                        pass;
        logic                        fail;
        logic [3:0]                  retry;   // pulses given in verify loop
        logic [15:0]                 cnt;     // delay counter
        logic                        idw;     // id word being read
        logic [otp_pkg::DATA_W-1:0]  mk;
        logic [otp_pkg::DATA_W-1:0]  pt;
    } otp_regs_t;

    otp_regs_t cur_ff;    // registered state
    otp_regs_t nxt_cur;   // next state

    localparam logic [15:0] PULSE_LD = 16'(PULSE_CYCLES - 1);
    localparam logic [15:0] SETUP_LD = 16'(otp_pkg::SETUP_CYC - 1);
    localparam logic [15:0] RD_LD    = 16'(otp_pkg::RD_CYC - 1);
    localparam logic [otp_pkg::ADDR_W-1:0] LAST_A = otp_pkg::ADDR_W'(LAST_ADDR);

    // address with only the id-word select bit set
    function automatic logic [otp_pkg::ADDR_W-1:0] id_addr(input logic sel);
        id_addr = {{(otp_pkg::ADDR_W-1){1'b0}}, sel};
    endfunction

    // =========================================================
    // next state
    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.req  = 1'b0;
        nxt_cur.done = 1'b0;
        if (cur_ff.cnt != 16'h0) begin
            nxt_cur.cnt = cur_ff.cnt - 16'h1;
        end
        case (cur_ff.st)
            S_IDLE: begin
                // bus quiet, device deselected so it floats outputs
                nxt_cur.ce_n  = 1'b1;                            // R9
                nxt_cur.oe_n  = 1'b1;
                nxt_cur.stb_n = 1'b1;
                nxt_cur.woe   = 1'b0;
                if (start_prog_in) begin
                    nxt_cur.addr  = '0;                           // R2
                    nxt_cur.sup   = otp_pkg::SUP_PROG;            // R2
                    nxt_cur.ph    = P_FIRST;
                    nxt_cur.busy  = 1'b1;
                    nxt_cur.pass  = 1'b0;
                    nxt_cur.fail  = 1'b0;
                    nxt_cur.cnt   = SETUP_LD;
                    nxt_cur.st    = S_SUPPLY;
                end else if (start_id_in) begin
                    nxt_cur.addr  = id_addr(1'b0);                // R10
                    nxt_cur.sup   = otp_pkg::SUP_ID;
                    nxt_cur.hv    = 1'b1;                         // R10
                    nxt_cur.idw   = 1'b0;
                    nxt_cur.busy  = 1'b1;
                    nxt_cur.cnt   = SETUP_LD;
                    nxt_cur.st    = S_ID_SET;
                end
            end
            S_SUPPLY: begin
                // supplies settle before any strobe
                if (cur_ff.cnt == 16'h0) begin
                    nxt_cur.req = 1'b1;
                    nxt_cur.st  = S_FETCH;
                end
            end
            S_FETCH: begin
                // source word is present this cycle
                nxt_cur.wdat = src_data_in;
                nxt_cur.ce_n = 1'b0;
                if (cur_ff.ph == P_FIRST) begin
                    nxt_cur.woe  = 1'b1;                          // R3
                    nxt_cur.oe_n = 1'b1;                          // R12
                    nxt_cur.cnt  = SETUP_LD;
                    nxt_cur.st   = S_SETUP;
                end else begin
                    nxt_cur.woe  = 1'b0;
                    nxt_cur.oe_n = 1'b0;                          // R12
                    nxt_cur.retry = 4'h0;
                    nxt_cur.cnt  = RD_LD;
                    nxt_cur.st   = S_VREAD;
                end
            end
            S_SETUP: begin
                if (cur_ff.cnt == 16'h0) begin
                    nxt_cur.stb_n = 1'b0;                         // R12
                    nxt_cur.cnt   = PULSE_LD;
                    nxt_cur.st    = S_PULSE;
                end
            end
            S_PULSE: begin
                // one fixed-width pulse; exactly PULSE_CYCLES low
                if (cur_ff.cnt == 16'h0) begin
                    nxt_cur.stb_n = 1'b1;                         // R1
                    nxt_cur.cnt   = SETUP_LD;
                    nxt_cur.st    = S_HOLD;
                end
            end
            S_HOLD: begin
                // data hold, then verify read or move on
                if (cur_ff.cnt == 16'h0) begin
                    nxt_cur.woe = 1'b0;
                    if (cur_ff.ph == P_FIRST) begin
                        nxt_cur.st = S_NEXT;                      // R3
                    end else begin
                        nxt_cur.oe_n = 1'b0;                      // R4
                        nxt_cur.cnt  = RD_LD;
                        nxt_cur.st   = S_VREAD;
                    end
                end
            end
            S_VREAD: begin
                if (cur_ff.cnt == 16'h0) begin
                    nxt_cur.st = S_VCMP;
                end
            end
            S_VCMP: begin
                nxt_cur.oe_n = 1'b1;
                if (word_outputs_in == cur_ff.wdat) begin
                    nxt_cur.st = S_NEXT;                          // R6
                end else if (cur_ff.ph == P_FINAL ||
                             cur_ff.retry == 4'(otp_pkg::RETRY_MAX)) begin
                    nxt_cur.fail = 1'b1;                          // R5
                    nxt_cur.st   = S_DONE;
                end else begin
                    nxt_cur.retry = cur_ff.retry + 4'h1;          // R4
                    nxt_cur.woe   = 1'b1;
                    nxt_cur.cnt   = SETUP_LD;
                    nxt_cur.st    = S_SETUP;
                end
            end
            S_NEXT: begin
                nxt_cur.ce_n = 1'b1;
                if (cur_ff.addr != LAST_A) begin
                    nxt_cur.addr = cur_ff.addr + 16'h1;           // R6
                    nxt_cur.req  = 1'b1;
                    nxt_cur.st   = S_FETCH;
                end else begin
                    nxt_cur.addr = '0;
                    nxt_cur.req  = 1'b1;
                    nxt_cur.st   = S_FETCH;
                    if (cur_ff.ph == P_FIRST) begin
                        nxt_cur.ph = P_VERIFY;
                    end else if (cur_ff.ph == P_VERIFY) begin
                        nxt_cur.ph  = P_FINAL;
                        nxt_cur.sup = otp_pkg::SUP_READ;          // R7
                        nxt_cur.req = 1'b0;
                        nxt_cur.cnt = SETUP_LD;
                        nxt_cur.st  = S_SUPPLY;
                    end else begin
                        nxt_cur.req  = 1'b0;
                        nxt_cur.pass = 1'b1;                      // R7
                        nxt_cur.st   = S_DONE;
                    end
                end
            end
            S_DONE: begin
                nxt_cur.ce_n  = 1'b1;
                nxt_cur.oe_n  = 1'b1;
                nxt_cur.stb_n = 1'b1;
                nxt_cur.woe   = 1'b0;
                nxt_cur.sup   = otp_pkg::SUP_READ;
                nxt_cur.hv    = 1'b0;
                nxt_cur.busy  = 1'b0;
                nxt_cur.done  = 1'b1;
                nxt_cur.st    = S_IDLE;
            end
            S_ID_SET: begin
                if (cur_ff.cnt == 16'h0) begin
                    nxt_cur.ce_n = 1'b0;
                    nxt_cur.oe_n = 1'b0;
                    nxt_cur.cnt  = RD_LD;
                    nxt_cur.st   = S_ID_READ;
                end
            end
            S_ID_READ: begin
                if (cur_ff.cnt == 16'h0) begin
                    if (!cur_ff.idw) begin
                        nxt_cur.mk   = word_outputs_in;           // R8
                        nxt_cur.idw  = 1'b1;
                        nxt_cur.addr = id_addr(1'b1);             // R11
                        nxt_cur.cnt  = RD_LD;
                    end else begin
                        nxt_cur.pt   = word_outputs_in;           // R8
                        nxt_cur.st   = S_DONE;
                    end
                end
            end
            default: nxt_cur.st = S_IDLE;
        endcase
    end

    // =========================================================
    // register
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cur_ff       <= '0;
            cur_ff.st    <= S_IDLE;
            cur_ff.ph    <= P_FIRST;
            cur_ff.ce_n  <= 1'b1;
            cur_ff.oe_n  <= 1'b1;
            cur_ff.stb_n <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign word_address_lines_out = cur_ff.addr;
    assign word_drive_out         = cur_ff.wdat;
    assign word_drive_oe_out      = cur_ff.woe;
    assign chip_sel_n_out         = cur_ff.ce_n;
    assign out_drive_n_out        = cur_ff.oe_n;
    assign program_strobe_n_out   = cur_ff.stb_n;
    assign supply_sel_out         = cur_ff.sup;
    assign hv_id_en_out           = cur_ff.hv;
    assign src_req_out            = cur_ff.req;
    assign busy_out               = cur_ff.busy;
    assign done_out               = cur_ff.done;
    assign pass_out               = cur_ff.pass;
    assign fail_out               = cur_ff.fail;
    assign maker_id_out           = cur_ff.mk;
    assign part_id_out            = cur_ff.pt;

    // =========================================================
    // checks
    sequence strobe_fall;
        $fell(cur_ff.stb_n);
    endsequence
    chk_strobe_width: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        strobe_fall |-> !cur_ff.stb_n [*8]) else $error("strobe too short"); // R1
    chk_prog_supply: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !cur_ff.stb_n |-> cur_ff.sup == otp_pkg::SUP_PROG) else $error("pulse w/o supply"); // R2
    // id reads run in whatever phase the last job left, P_FIRST after reset, so only the program supply marks pass one
    chk_first_noread: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cur_ff.ph == P_FIRST && cur_ff.sup == otp_pkg::SUP_PROG |-> cur_ff.oe_n)
        else $error("read in pass 1"); // R3
    chk_retry_bound: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cur_ff.retry <= 4'(otp_pkg::RETRY_MAX)) else $error("too many retries"); // R4
    chk_fail_stop: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(cur_ff.fail) |-> cur_ff.st == S_DONE ##1 !cur_ff.busy) else $error("fail not stopped"); // R5
    chk_final_supply: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(cur_ff.pass) |-> cur_ff.sup == otp_pkg::SUP_READ) else $error("pass w/o read supply"); // R7
    chk_pin_combo: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !cur_ff.stb_n |-> !cur_ff.ce_n && cur_ff.oe_n && cur_ff.woe) else $error("bad prog pins"); // R12
    chk_id_addr: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cur_ff.st == S_ID_READ |-> cur_ff.hv && cur_ff.addr[otp_pkg::ADDR_W-1:1] == '0)
        else $error("id address not low"); // R10
    chk_no_contend: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cur_ff.woe |-> cur_ff.oe_n) else $error("bus contention"); // R9
endmodule // otp_host
`default_nettype wire

//--- otp_pkg.sv
/*
 * otp_pkg: constants shared by the otp programmer host controller.
 * assumes a 125 MHz reference clock; supply levels are requested as codes
 * that an external regulator turns into voltages.
 */
`default_nettype none
package otp_pkg;
    // =========================================================
    // geometry
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 16;
    // =========================================================
    // timing
    localparam int CLK_MHZ     = 125;
    localparam int PULSE_NOM_US = 100;   // nominal strobe width
    localparam int PULSE_MIN_US = 95;
    localparam int PULSE_MAX_US = 105;
    localparam int PULSE_CYC   = PULSE_NOM_US * CLK_MHZ;       // 12500
    localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
    localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
    localparam int SETUP_US    = 2;      // address/data/supply setup
    localparam int SETUP_CYC   = SETUP_US * CLK_MHZ;           // 250
    localparam int RD_NS       = 150;    // data valid from output drive
    localparam int RD_CYC      = (RD_NS * CLK_MHZ + 999) / 1000; // 19
    localparam int RETRY_MAX   = 10;
    // =========================================================
    // supply request codes
    localparam logic [1:0] SUP_READ = 2'h0;  // core 5.0V, prog 5.0V
    localparam logic [1:0] SUP_PROG = 2'h1;  // core 6.5V, prog 13.0V
    localparam logic [1:0] SUP_ID   = 2'h2;  // read supply, id line 12.0V
    localparam int ID_LINE_BIT = 9;          // address bit carrying id high voltage
endpackage
`default_nettype wire

//--- otp_dev_model.sv
/*
 * otp_dev_model: behavioural otp word memory seen only through its pins.
 * assumes the testbench resolves the shared data bus and calls new_part
 * to fit a blank part before each programming run.
 */
`timescale 1ns/1ns
`default_nettype none
module otp_dev_model #(
    parameter logic [15:0] MAKER_CODE = 16'h0042,  // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h00a7,  // arbitrary value
    parameter int          LAST_ADDR  = 3
) (
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] din_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        stb_n_in,
    input  wire logic [1:0]  supply_in,
    input  wire logic        hv_id_in,
    output logic      [15:0] dout_out
);
    // ==========================================================
    // cell array and bookkeeping for the bench
    logic [15:0] mem [0:LAST_ADDR];    // blank cells read all ones
    int          pulses [0:LAST_ADDR]; // strobe pulses taken per word
    int          weak_addr;            // word that resists programming
    int          weak_need;            // pulses it needs before it takes
    int          early_reads;          // verify reads before pass one ended
    int          final_reads;          // reads at normal supply
    int          bad_pulses;           // strobes outside program mode
    time         t_fall;               // start of the current strobe
    time         last_width;           // width of the last strobe
    logic        sel;                  // outputs driven
    logic [15:0] val;                  // word the device would show
    logic [15:0] held = 16'h0000;      // last word shown, to spoil a float

    // fit a fresh blank part
    task automatic new_part(input int wa, input int need);
        for (int i = 0; i <= LAST_ADDR; i++) begin
            mem[i] = 16'hffff;
            pulses[i] = 0;
        end
        weak_addr = wa;
        weak_need = need;
        early_reads = 0;
        final_reads = 0;
        bad_pulses = 0;
    endtask

    // ==========================================================
    // programming: cells take the data when the strobe ends
    always @(negedge stb_n_in) t_fall = $time;
    always @(posedge stb_n_in) begin
        if (!ce_n_in && oe_n_in && supply_in == otp_pkg::SUP_PROG) begin
            last_width = $time - t_fall;
            pulses[addr_in] += 1;
            // a weak word ignores pulses until enough have landed
            if (addr_in != weak_addr || pulses[addr_in] >= weak_need) begin
                mem[addr_in] = mem[addr_in] & din_in;  // one-time cells only clear
            end
        end else begin
            bad_pulses++;
        end
    end

    // read accounting; the delay lets the selects settle together
    always @(negedge oe_n_in) begin
        #1;
        if (!ce_n_in && supply_in == otp_pkg::SUP_PROG && pulses[LAST_ADDR] == 0) begin
            early_reads++;
        end
        if (!ce_n_in && supply_in == otp_pkg::SUP_READ) begin
            final_reads++;
        end
    end

    // ==========================================================
    // output word: array or identification words
    assign sel = !ce_n_in && !oe_n_in;
    // continuous assign so a cell that takes a retry pulse shows up at once
    assign val = (hv_id_in && supply_in == otp_pkg::SUP_ID) ?
                 (addr_in[0] ? {8'h00, PART_CODE[7:0]} : {8'h00, MAKER_CODE[7:0]}) :
                 mem[addr_in];
    always @(val or sel) if (sel) held = val;
    // a floating bus must not keep the old word, so show its inverse
    assign dout_out = sel ? val : ~held;
endmodule // otp_dev_model
`default_nettype wire

//--- otp_word_memory_program_verify_test.sv
/*
 * otp_word_memory_program_verify_test: self-checking bench for otp_host.
 * assumes otp_host and otp_dev_model are compiled; short pulse and four words.
 */
`timescale 1ns/1ns
`default_nettype none
module otp_word_memory_program_verify_test;
    // ==========================================================
    // settings and wires
    localparam int          PULSE = 20;        // shortened strobe in cycles
    localparam int          LAST  = 3;         // last word address
    localparam logic [15:0] MAKER = 16'h0042;  // arbitrary value
    localparam logic [15:0] PART  = 16'h00a7;  // arbitrary value
    logic        ref_clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        start_prog_in = 1'b0;
    logic        start_id_in = 1'b0;
    logic [15:0] src_data_in = 16'h0000;
    logic [15:0] word_outputs_in, word_address_lines_out, word_drive_out;
    logic [15:0] maker_id_out, part_id_out, dev_out;
    logic        word_drive_oe_out, chip_sel_n_out, out_drive_n_out;
    logic        program_strobe_n_out, hv_id_en_out, src_req_out;
    logic        busy_out, done_out, pass_out, fail_out;
    logic [1:0]  supply_sel_out;
    int          fail_count = 0;
    int          n_tests = 0;

    always #4 ref_clk_in = ~ref_clk_in;  // 125 MHz

    otp_host #(.PULSE_CYCLES(PULSE), .LAST_ADDR(LAST)) dut_u (.ref_clk_in, .rst_b_in,
        .start_prog_in, .start_id_in, .src_data_in, .word_outputs_in,
        .word_address_lines_out, .word_drive_out, .word_drive_oe_out, .chip_sel_n_out,
        .out_drive_n_out, .program_strobe_n_out, .supply_sel_out, .hv_id_en_out,
        .src_req_out, .busy_out, .done_out, .pass_out, .fail_out, .maker_id_out,
        .part_id_out);
    otp_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .LAST_ADDR(LAST)) dev_u (
        .addr_in(word_address_lines_out), .din_in(word_outputs_in),
        .ce_n_in(chip_sel_n_out), .oe_n_in(out_drive_n_out),
        .stb_n_in(program_strobe_n_out), .supply_in(supply_sel_out),
        .hv_id_in(hv_id_en_out), .dout_out(dev_out));

    // bus: whoever enables wins; the model spoils the bus when floating
    assign word_outputs_in = word_drive_oe_out ? word_drive_out : dev_out;

    // source image, offered for whatever address is on the pins
    function automatic logic [15:0] src_word(input logic [15:0] a);
        return 16'h5a3c ^ (a * 16'h0111);
    endfunction
    always @(negedge ref_clk_in) src_data_in <= src_word(word_address_lines_out);

    // ==========================================================
    // shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one start pulse, then wait for done under a bound
    task automatic run(input logic id);
        int n;
        logic [1:0] sup_exp;
        sup_exp = id ? otp_pkg::SUP_ID : otp_pkg::SUP_PROG;
        @(negedge ref_clk_in);
        start_id_in = id;
        start_prog_in = !id;
        @(negedge ref_clk_in);
        start_id_in = 1'b0;
        start_prog_in = 1'b0;
        // start taken: busy, supply and id line follow the requested job
        check("busy_out", {15'h0000, busy_out}, 16'h0001);
        check("supply_sel_out", {14'h0000, supply_sel_out}, {14'h0000, sup_exp});
        check("hv_id_en_out", {15'h0000, hv_id_en_out}, {15'h0000, id});
        n = 0;
        while (done_out !== 1'b1 && n < 30000) begin
            @(negedge ref_clk_in);
            n++;
        end
        check("done_out", {15'h0000, done_out}, 16'h0001);
        check("busy_out", {15'h0000, busy_out}, 16'h0000);
    endtask

    // program a part whose word wa needs need pulses and judge the outcome
    task automatic prog_case(input int wa, input int need, input logic ok);
        dev_u.new_part(wa, need);
        run(1'b0);
        check("pass_out", {15'h0000, pass_out}, {15'h0000, ok});
        check("fail_out", {15'h0000, fail_out}, {15'h0000, !ok});
        check("early_reads", 16'(dev_u.early_reads), 16'h0000);
        check("bad_pulses", 16'(dev_u.bad_pulses), 16'h0000);
        check("pulse_width", 16'(dev_u.last_width), 16'(PULSE * 8));
        for (int a = 0; a <= LAST; a++) begin
            if (a == wa) begin
                check("weak_pulses", 16'(dev_u.pulses[a]), 16'(ok ? need : 11));
            end else if (ok || a < wa) begin
                check("word_pulses", 16'(dev_u.pulses[a]), 16'h0001);
                check("cell_word", dev_u.mem[a], src_word(16'(a)));
            end else begin
                check("word_pulses", 16'(dev_u.pulses[a]), 16'h0001);
            end
        end
        check("final_reads", 16'(dev_u.final_reads), ok ? 16'(LAST + 1) : 16'h0000);
        $display("test program weak %0d need %0d finished", wa, need);
    endtask

    task automatic test_id();
        run(1'b1);
        check("maker_id_out", maker_id_out, MAKER);
        check("part_id_out", part_id_out, PART);
        $display("test id finished");
    endtask

    // reset in mid-run; an id start while busy must be ignored
    task automatic test_reset();
        dev_u.new_part(-1, 1);
        @(negedge ref_clk_in);
        start_prog_in = 1'b1;
        @(negedge ref_clk_in);
        start_prog_in = 1'b0;
        start_id_in = 1'b1;
        @(negedge ref_clk_in);
        start_id_in = 1'b0;
        check("hv_id_en_out", {15'h0000, hv_id_en_out}, 16'h0000);
        repeat (300) @(negedge ref_clk_in);
        check("chip_sel_n_out", {15'h0000, chip_sel_n_out}, 16'h0000);
        rst_b_in = 1'b0;
        @(negedge ref_clk_in);
        check("busy_out", {15'h0000, busy_out}, 16'h0000);
        check("strobe_n_out", {15'h0000, program_strobe_n_out}, 16'h0001);
        check("chip_sel_n_out", {15'h0000, chip_sel_n_out}, 16'h0001);
        rst_b_in = 1'b1;
        $display("test reset finished");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        dev_u.new_part(-1, 1);
        repeat (2) @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        test_id();
        test_reset();
        prog_case(-1, 1, 1'b1);
        prog_case(2, 6, 1'b1);
        prog_case(3, 11, 1'b1);
        prog_case(1, 12, 1'b0);
        test_id();
        stop_test();
    end

    // watchdog: all cases together take well under this many cycles
    initial begin
        repeat (90000) @(posedge ref_clk_in);
        fail_count++;
        $display("unexpected watchdog expiry");
        stop_test();
    end
endmodule // otp_word_memory_program_verify_test
`default_nettype wire
